/* File: design/tscp_pkg.sv */
// Function
// - Command byte: row, two mode bits, read bit
// - Mode 01 read: low byte first, rows up
// - Mode 10 read: high byte first, rows down
// - Row pointer wraps, reading continues
// - Read, nack, stop returns port to idle
// - Special byte disables memory until stop
// - Modulator mode: SCL clocks, SDA is data
// - No acknowledge during modulator stream
// - 1100x111 bi-phase, 1101x111 Manchester
// - 111x0111 turns supply management off
// - 111x1111 turns supply management on
package tscp_pkg;
  // ==========================================
  // Memory shape
  localparam int ROW_W = 5;
  localparam int BYTE_W = 8;
  // ==========================================
  // Command byte fields
  localparam int CMD_RD_POS = 0;
  localparam int CMD_C0_POS = 1;
  localparam int CMD_C1_POS = 2;
  localparam int CMD_ROW_LSB = 3;
  localparam int SPEC_SEL_LSB = 4;
  localparam int SPEC_PM_POS = 3;
  localparam logic [2:0] CMD_SPECIAL_LOW = 3'h7;
  localparam logic [1:0] CMD_SPECIAL_TAG = 2'h3;
  localparam logic [1:0] SPEC_SEL_BIPHASE = 2'h0;
  localparam logic [1:0] SPEC_SEL_MANCH = 2'h1;
  // ==========================================
  // Reset values
  localparam logic SUPPLY_MGMT_RST = 1'b1;
  // ==========================================
  // Timing
  localparam int CORE_PERIOD_NS = 40;
  localparam int STOP_IDLE_NS = 160;
  localparam int STOP_IDLE_CYC =
    (STOP_IDLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // ==========================================
  // Link states
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_CMD = 3'h1,
    LK_CACK = 3'h2,
    LK_RD = 3'h3,
    LK_RACK = 3'h4,
    LK_SPEC = 3'h5
  } tscp_lk_st_type;
endpackage

/* File: design/tscp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tscp_port #(
  parameter int AW = 1,
  parameter int STOP_CYC = tscp_pkg::STOP_IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [511:0] mem_image,
  output logic mod_bit,
  output logic mod_bit_valid,
  input wire logic mod_bit_ready,
  output logic mod_active,
  output logic mod_manchester,
  output logic supply_mgmt_on,
  output logic stream_overrun
);
  localparam int DEPTH = 2 ** AW;
  // Full when the two top gray bits differ and the rest agree
  localparam logic [AW:0] FULL_XOR = (AW + 1)'(3) << (AW - 1);
  // Refuse shapes the logic cannot serve
  if (AW != 1 || STOP_CYC < 1 || STOP_CYC > 255) begin : g_bad
    $error("tscp_port: AW must be 1, STOP_CYC 1..255");
  end

  // ==========================================
  // Link side state (rising SCL)
  typedef struct packed {
    tscp_pkg::tscp_lk_st_type st;
    logic [2:0] bcnt;        // Bit within byte
    logic [7:0] sh;          // Incoming shift
    logic [7:0] tx;          // Outgoing byte
    logic [4:0] row;         // Row pointer
    logic hi_first;          // High byte first
    logic dec;               // Row steps down
    logic half;              // Second byte of word
    logic spec;              // Special byte taken
    logic [7:0] cmd;         // Held command byte
    logic cmd_tgl;           // Command event toggle
    logic ovr;               // Stream bit dropped
    logic [AW:0] wg;         // Write pointer gray, crosses to core
    logic [AW:0] wbin;       // Write pointer
    logic [AW:0] rg1;        // Read gray, stage 1
    logic [DEPTH-1:0] fifo;  // Stream bit store
    logic [511:0] m1;        // Memory image, stage 1
    logic [511:0] m2;        // Memory image, stage 2
  } tscp_lk_type;

  // Link side state (falling SCL)
  typedef struct packed {
    logic start;      // Start seen in last high phase
    logic seen;       // Start toggle already taken
    logic [AW:0] rg2; // Read gray, stage 2, half a period later
    logic oe;         // Pull SDA low
  } tscp_ng_type;

  // ==========================================
  // Core side state
  typedef struct packed {
    logic scl1, scl2, sda1, sda2;  // Pin sync
    logic [7:0] icnt;              // Bus idle count
    logic tg1, tg2, tg3;           // Command toggle sync
    logic [AW:0] wg1, wg2;         // Write gray sync
    logic [AW:0] rbin;             // Read pointer
    logic [AW:0] rg;               // Read pointer gray
    logic ov1, ov2;                // Overrun sync
    logic out_v, out_b;            // Stream output
    logic act, manch, supply;      // Mode outputs
  } tscp_cr_type;

  tscp_lk_type lk_r, lk_nxt;
  tscp_ng_type ng_r, ng_nxt;
  tscp_cr_type cr_r, cr_nxt;
  logic lrst1_r, lrst2_r;  // Reset carried into SCL domain
  logic st_tgl_r;  // Toggles at each start condition
  logic [AW:0] wgray;
  logic full;
  logic [7:0] cb;
  logic [15:0] word, nword;
  logic [4:0] nrow;
  logic empty, stop_det, cmd_ev;
  logic [7:0] ccmd;

  // ==========================================
  // Reset sync for the link; SCL stands still between
  // frames, so reset lands at the next SCL edges
  always_ff @(posedge scl_clk) begin
    lrst1_r <= sys_rst;
    lrst2_r <= lrst1_r;
  end

  // ==========================================
  // Link next state
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.m1 = mem_image;
    lk_nxt.m2 = lk_r.m1;
    lk_nxt.rg1 = cr_r.rg;
    wgray = lk_r.wg;
    // Second stage sits on the falling edge so a drained slot is seen next rise
    full = ((wgray ^ ng_r.rg2) == FULL_XOR);
    cb = {lk_r.sh[6:0], sda_i};
    word = lk_r.m2[{lk_r.row, 4'h0} +: 16];
    // 5-bit pointer wraps by itself
    nrow = lk_r.dec ? lk_r.row - 5'h01 : lk_r.row + 5'h01;
    nword = lk_r.m2[{nrow, 4'h0} +: 16];
    // Relies on SDA holding still while SCL high
    if (ng_r.start) begin
      lk_nxt.st = tscp_pkg::LK_CMD;
      lk_nxt.sh = {7'h00, sda_i};
      lk_nxt.bcnt = 3'h1;
      lk_nxt.ovr = 1'b0;
    end else begin
      case (lk_r.st)
        tscp_pkg::LK_CMD: begin
          // Shift in the command byte
          lk_nxt.sh = cb;
          lk_nxt.bcnt = lk_r.bcnt + 3'h1;
          if (lk_r.bcnt == 3'h7) begin
            lk_nxt.cmd = cb;
            lk_nxt.row = cb[7:tscp_pkg::CMD_ROW_LSB];
            lk_nxt.hi_first = cb[tscp_pkg::CMD_C1_POS];
            lk_nxt.dec = cb[tscp_pkg::CMD_C1_POS] &
              ~cb[tscp_pkg::CMD_C0_POS];
            lk_nxt.spec = 1'b0;
            if (cb[2:0] == tscp_pkg::CMD_SPECIAL_LOW &&
                cb[7:6] == tscp_pkg::CMD_SPECIAL_TAG) begin
              // Announce to the core, then ack
              lk_nxt.spec = 1'b1;
              lk_nxt.cmd_tgl = ~lk_r.cmd_tgl;
              lk_nxt.st = tscp_pkg::LK_CACK;
            end else if (cb[tscp_pkg::CMD_RD_POS] &&
                         cb[2:0] != tscp_pkg::CMD_SPECIAL_LOW) begin
              lk_nxt.st = tscp_pkg::LK_CACK;
            end else begin
              // Writes, reserved and stray bytes: no ack
              lk_nxt.st = tscp_pkg::LK_IDLE;
            end
          end
        end
        tscp_pkg::LK_CACK: begin
          // Ack clock done; load first byte of the word
          lk_nxt.bcnt = 3'h0;
          lk_nxt.half = 1'b0;
          lk_nxt.tx = lk_r.hi_first ? word[15:8] : word[7:0];
          lk_nxt.st = lk_r.spec ? tscp_pkg::LK_SPEC : tscp_pkg::LK_RD;
        end
        tscp_pkg::LK_RD: begin
          lk_nxt.bcnt = lk_r.bcnt + 3'h1;
          if (lk_r.bcnt == 3'h7) begin
            lk_nxt.st = tscp_pkg::LK_RACK;
          end
        end
        tscp_pkg::LK_RACK: begin
          if (sda_i) begin
            // No ack from master ends the read
            lk_nxt.st = tscp_pkg::LK_IDLE;
          end else begin
            lk_nxt.st = tscp_pkg::LK_RD;
            lk_nxt.bcnt = 3'h0;
            lk_nxt.half = ~lk_r.half;
            if (!lk_r.half) begin
              lk_nxt.tx = lk_r.hi_first ? word[7:0] : word[15:8];
            end else begin
              lk_nxt.row = nrow;
              lk_nxt.tx = lk_r.hi_first ? nword[15:8] : nword[7:0];
            end
          end
        end
        tscp_pkg::LK_SPEC: begin
          // Each SCL pulse is one modulator bit
          if (!full) begin
            lk_nxt.fifo[lk_r.wbin[AW-1:0]] = sda_i;
            lk_nxt.wbin = lk_r.wbin + 1'b1;
            lk_nxt.wg = lk_nxt.wbin ^ (lk_nxt.wbin >> 1);
          end else begin
            // No clock stretching exists, so flag the loss
            lk_nxt.ovr = 1'b1;
          end
        end
        default: lk_nxt.st = tscp_pkg::LK_IDLE;
      endcase
    end
  end

  // Link register
  always_ff @(posedge scl_clk) begin
    if (lrst2_r) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ==========================================
  // Start toggle: SDA falling while SCL high; a stop gives no SCL edge
  // before the next start, so SDA itself must clock this flop
  always_ff @(negedge sda_i or posedge lrst2_r) begin
    if (lrst2_r) begin
      st_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      st_tgl_r <= ~st_tgl_r;
    end
  end

  // ==========================================
  // Falling SCL: start detect and SDA drive
  always_comb begin
    ng_nxt.start = st_tgl_r ^ ng_r.seen;
    ng_nxt.seen = st_tgl_r;
    ng_nxt.rg2 = lk_r.rg1;
    ng_nxt.oe = 1'b0;
    if (!ng_nxt.start) begin
      case (lk_r.st)
        tscp_pkg::LK_CACK: ng_nxt.oe = 1'b1;
        tscp_pkg::LK_RD: ng_nxt.oe = ~lk_r.tx[~lk_r.bcnt];
        // Stream and idle leave SDA alone
        default: ng_nxt.oe = 1'b0;
      endcase
    end
  end

  // Falling-edge register
  always_ff @(negedge scl_clk) begin
    if (lrst2_r) begin
      ng_r <= '0;
    end else begin
      ng_r <= ng_nxt;
    end
  end

  // ==========================================
  // Core next state
  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.scl1 = scl_clk;
    cr_nxt.scl2 = cr_r.scl1;
    cr_nxt.sda1 = sda_i;
    cr_nxt.sda2 = cr_r.sda1;
    cr_nxt.tg1 = lk_r.cmd_tgl;
    cr_nxt.tg2 = cr_r.tg1;
    cr_nxt.tg3 = cr_r.tg2;
    cr_nxt.wg1 = lk_r.wg;
    cr_nxt.wg2 = cr_r.wg1;
    cr_nxt.ov1 = lk_r.ovr;
    cr_nxt.ov2 = cr_r.ov1;
    // Stop shows as both lines high for a while
    if (cr_r.scl2 && cr_r.sda2) begin
      if (cr_r.icnt != STOP_CYC[7:0]) begin
        cr_nxt.icnt = cr_r.icnt + 8'h01;
      end
    end else begin
      cr_nxt.icnt = 8'h00;
    end
    stop_det = cr_r.scl2 && cr_r.sda2 &&
      (cr_r.icnt == STOP_CYC[7:0] - 8'h01);
    // Command byte is held still long after its toggle
    cmd_ev = cr_r.tg2 ^ cr_r.tg3;
    ccmd = lk_r.cmd;
    if (stop_det) begin
      cr_nxt.act = 1'b0;
    end
    if (cmd_ev) begin
      case (ccmd[5:4])
        tscp_pkg::SPEC_SEL_BIPHASE: begin
          cr_nxt.act = 1'b1;
          cr_nxt.manch = 1'b0;
        end
        tscp_pkg::SPEC_SEL_MANCH: begin
          cr_nxt.act = 1'b1;
          cr_nxt.manch = 1'b1;
        end
        default: cr_nxt.supply = ccmd[tscp_pkg::SPEC_PM_POS];
      endcase
    end
    // Drain the buffer into the output register
    empty = (cr_r.wg2 == cr_r.rg);
    if (!cr_r.out_v || mod_bit_ready) begin
      cr_nxt.out_v = !empty;
      if (!empty) begin
        cr_nxt.out_b = lk_r.fifo[cr_r.rbin[AW-1:0]];
        cr_nxt.rbin = cr_r.rbin + 1'b1;
        cr_nxt.rg = cr_nxt.rbin ^ (cr_nxt.rbin >> 1);
      end
    end
  end

  // Core register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cr_r <= '0;
      cr_r.supply <= tscp_pkg::SUPPLY_MGMT_RST;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  // ==========================================
  // Outputs from flops, sda_o tied low
  assign sda_o = 1'b0;
  assign sda_oe = ng_r.oe;
  assign mod_bit = cr_r.out_b;
  assign mod_bit_valid = cr_r.out_v;
  assign mod_active = cr_r.act;
  assign mod_manchester = cr_r.manch;
  assign supply_mgmt_on = cr_r.supply;
  assign stream_overrun = cr_r.ov2;

  // ==========================================
  // Link checks
  sequence cmd_acked_s;
    (lk_r.st == tscp_pkg::LK_CACK) && !lk_r.spec;
  endsequence
  sequence word_done_s;
    lk_r.st == tscp_pkg::LK_RACK && !sda_i && lk_r.half && !ng_r.start;
  endsequence

  ack_drive_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (lk_r.st == tscp_pkg::LK_CACK && !ng_r.start) |-> sda_oe)
    else $error("command not acknowledged");
  stream_quiet_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (lk_r.st == tscp_pkg::LK_SPEC) |=> !sda_oe)
    else $error("acknowledge driven in stream");
  low_first_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (cmd_acked_s and !lk_r.hi_first && !ng_r.start) |=>
      lk_r.tx == lk_r.m2[{lk_r.row, 4'h0} +: 8])
    else $error("low byte not first");
  high_first_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (cmd_acked_s and lk_r.hi_first && !ng_r.start) |=>
      lk_r.tx == lk_r.m2[{lk_r.row, 4'h8} +: 8])
    else $error("high byte not first");
  row_step_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    word_done_s |=> lk_r.row == ($past(lk_r.dec) ?
      $past(lk_r.row) - 5'h01 : $past(lk_r.row) + 5'h01))
    else $error("row pointer step wrong");
  nack_idle_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (lk_r.st == tscp_pkg::LK_RACK && sda_i && !ng_r.start) |=>
      lk_r.st == tscp_pkg::LK_IDLE ##1 !sda_oe)
    else $error("no return to idle after nack");
  reserved_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (lk_r.st == tscp_pkg::LK_CMD && lk_r.bcnt == 3'h7 && !ng_r.start &&
     cb[2:0] == 3'h6) |=> lk_r.st == tscp_pkg::LK_IDLE)
    else $error("reserved byte started action");
  bit_push_a: assert property (@(posedge scl_clk) disable iff (lrst2_r)
    (lk_r.st == tscp_pkg::LK_SPEC && !full && !ng_r.start) |=>
      lk_r.wbin == $past(lk_r.wbin) + 1'b1 && lk_r.ovr == $past(lk_r.ovr))
    else $error("stream bit not taken");

  // ==========================================
  // Core checks
  stop_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (stop_det && !cmd_ev) |=> !mod_active)
    else $error("mode kept after stop");
  manch_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_ev && ccmd[5:4] == 2'h1) |=> mod_active && mod_manchester)
    else $error("manchester not selected");
  supply_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_ev && ccmd[5] && !ccmd[tscp_pkg::SPEC_PM_POS]) |=> !supply_mgmt_on)
    else $error("supply management not off");
  supply_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_ev && ccmd[5] && ccmd[tscp_pkg::SPEC_PM_POS]) |=> supply_mgmt_on)
    else $error("supply management not on");
endmodule
`default_nettype wire

/* File: test/tscp_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-wire master: makes SCL in frames and idle pulses, pulls SDA low
module tscp_master (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  int clash = 0; // Released bits that read low at the rise
  initial begin
    scl = 1'b1; // Idle high between frames
    sda_oe = 1'b0; // Released, the pull-up wins
  end
  // ==========================================
  // Bit level: data moves only while SCL is low
  task automatic wrbit(input logic b);
    sda_oe = !b;
    #24 scl = 1'b1;
    if (b && !sda) clash++;
    #24 scl = 1'b0;
  endtask
  task automatic rdbit(output logic b);
    sda_oe = 1'b0;
    #24 scl = 1'b1;
    b = sda; // Device set it at the previous fall
    #24 scl = 1'b0;
  endtask
  // Idle pulses: the link side takes reset only on SCL edges
  task automatic clocks(input int n);
    repeat (n) begin
      #24 scl = 1'b0;
      #24 scl = 1'b1;
    end
  endtask
  // ==========================================
  // Frame level
  task automatic start();
    sda_oe = 1'b1; // SDA falls while SCL is high
    #24 scl = 1'b0;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #24 scl = 1'b1;
    #24 sda_oe = 1'b0; // SDA rises while SCL is high
    #400; // Long enough for the core to see the stop
  endtask
  // Byte out, returns the level seen in the ack slot
  task automatic send(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--) begin
      wrbit(v[i]);
    end
    rdbit(a);
  endtask
  // Byte in, then ack or withhold ack on the last one
  task automatic recv(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      rdbit(v[i]);
    end
    wrbit(last);
  endtask
endmodule
`default_nettype wire

/* File: test/tscp_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the serial command port
module tscp_port_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl_clk, mst_oe, sda_o, sda_oe, sda_w, a;
  logic mod_bit, mod_bit_valid, mod_active, mod_manchester;
  logic supply_mgmt_on, stream_overrun;
  logic mod_bit_ready = 1'b1;
  logic [511:0] mem_image;
  logic [7:0] b;
  logic [8:0] sb = 9'h13b; // Stream pattern, longer than a byte
  logic q[$]; // Modulator bits taken by the consumer
  int failures = 0;
  int cmp_count = 0;
  // Open drain with pull-up: low if anyone pulls
  assign sda_w = !(mst_oe || sda_oe);
  always #20 core_clk = !core_clk;
  tscp_master tscp_master_inst (.scl(scl_clk), .sda_oe(mst_oe), .sda(sda_w));
  tscp_port #(.STOP_CYC(4)) tscp_port_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .mem_image(mem_image), .mod_bit(mod_bit),
    .mod_bit_valid(mod_bit_valid), .mod_bit_ready(mod_bit_ready),
    .mod_active(mod_active), .mod_manchester(mod_manchester),
    .supply_mgmt_on(supply_mgmt_on), .stream_overrun(stream_overrun));
  // Consumer side of the stream handshake
  always @(posedge core_clk) begin
    if ((mod_bit_valid && mod_bit_ready) === 1'b1) q.push_back(mod_bit);
  end
  // ==========================================
  // Memory pattern: each byte carries its row
  function automatic logic [7:0] hb(input logic [4:0] r);
    return {3'h5, r};
  endfunction
  function automatic logic [7:0] lb(input logic [4:0] r);
    return {3'h2, r};
  endfunction
  // ==========================================
  // Checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Four-byte read: three acked, last one withheld
  task automatic rd4(input logic [7:0] c, input logic [31:0] e);
    tscp_master_inst.start();
    tscp_master_inst.send(c, a);
    chk(a, 8'h00);
    for (int i = 0; i < 4; i++) begin
      tscp_master_inst.recv(i == 3, b);
      chk(b, e[31-8*i -: 8]);
    end
    tscp_master_inst.stop();
  endtask
  // Special command byte, acked by the port
  task automatic special(input logic [7:0] c);
    tscp_master_inst.start();
    tscp_master_inst.send(c, a);
    chk(a, 8'h00);
    #200;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    for (int r = 0; r < 32; r++) begin
      mem_image[16*r +: 16] = {hb(5'(r)), lb(5'(r))};
    end
    tscp_master_inst.clocks(4); // Link side needs pulses under reset
    repeat (12) @(posedge core_clk);
    #2 sys_rst = 1'b0;
    #100;
    tscp_master_inst.clocks(3); // Link leaves reset on SCL edges
    chk({sda_oe, mod_active, supply_mgmt_on, stream_overrun}, 8'h02);
    // Recovery: one byte, no ack, stop, then normal reads
    tscp_master_inst.start();
    tscp_master_inst.send(8'h0b, a);
    tscp_master_inst.recv(1'b1, b);
    chk(b, lb(5'h01));
    tscp_master_inst.stop();
    chk(sda_oe, 8'h00);
    rd4(8'hfb, {lb(5'h1f), hb(5'h1f), lb(5'h00), hb(5'h00)});
    rd4(8'h05, {hb(5'h00), lb(5'h00), hb(5'h1f), lb(5'h1f)});
    // Write direction and reserved low bits get no ack
    for (int i = 0; i < 2; i++) begin
      tscp_master_inst.start();
      tscp_master_inst.send(i == 0 ? 8'h0a : 8'h0e, a);
      chk(a, 8'h01);
      tscp_master_inst.stop();
    end
    // Bi-phase stream of nine bits, no ack slot after eight
    special(8'hc7);
    chk({mod_active, mod_manchester}, 8'h02);
    // SCL held low between bits so the two-entry buffer keeps pace
    for (int i = 8; i >= 0; i--) begin
      tscp_master_inst.wrbit(sb[i]);
      #200;
    end
    #400;
    chk(8'(q.size()), 8'h09);
    for (int i = 0; i < 9; i++) chk(q[i], sb[8-i]);
    tscp_master_inst.stop();
    chk(mod_active, 8'h00);
    // Manchester with the consumer stalled: the buffer overflows
    q.delete();
    @(posedge core_clk) #2 mod_bit_ready = 1'b0;
    special(8'hd7);
    chk({mod_active, mod_manchester}, 8'h03);
    for (int i = 8; i >= 4; i--) tscp_master_inst.wrbit(sb[i]);
    #400;
    chk(stream_overrun, 8'h01);
    @(posedge core_clk) #2 mod_bit_ready = 1'b1;
    #400;
    chk({q[0], q[1]}, {6'h00, sb[8], sb[7]});
    tscp_master_inst.stop();
    // Supply management off, memory silent until stop, then on
    special(8'he7);
    tscp_master_inst.recv(1'b1, b);
    chk(b, 8'hff);
    tscp_master_inst.stop();
    chk(supply_mgmt_on, 8'h00);
    special(8'hef);
    tscp_master_inst.stop();
    chk(supply_mgmt_on, 8'h01);
    chk(8'(tscp_master_inst.clash), 8'h00);
    results();
  end
  // Watchdog: the whole sequence needs well under this
  initial begin
    #200000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
